/* File: verilog/mpt_map.vh */
`ifndef MPT_MAP_VH
`define MPT_MAP_VH
// =====================================
// Match action encoding
`define MPT_ACT_CONTINUE 2'h0
`define MPT_ACT_STOP 2'h1
`define MPT_ACT_RESET 2'h2
// =====================================
// Sizes
`define MPT_NUM_MATCH 7
`define MPT_NUM_OUT 6
`define MPT_WIDTH 32
// =====================================
// Reset and increment values
`define MPT_ZERO32 32'h00000000
`define MPT_ONE32 32'h00000001
// =====================================
// Count source selection
`define MPT_SRC_CLOCK 2'h0
`define MPT_SRC_RISE 2'h1
`define MPT_SRC_FALL 2'h2
`define MPT_SRC_BOTH 2'h3
`endif

/* File: verilog/mpt_edge_detect.v */
`timescale 1ns/1ps
// =====================================
// Count event detector for capture inputs
module mpt_edge_detect (
	input wire core_clk,
	input wire reset_n,
	input wire [1:0] cap_sel,
	input wire [1:0] cap_in,
	input wire [1:0] src_mode,
	output reg count_event
);
`include "mpt_map.vh"
	reg prev_level;
	wire level;
	assign level = cap_sel[0] ? cap_in[1] : cap_in[0];
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_level <= 1'b0;
		end else begin
			prev_level <= level;
		end
	end
	always @* begin
		case (src_mode)
			`MPT_SRC_CLOCK: count_event = 1'b1;
			`MPT_SRC_RISE: count_event = level & ~prev_level;
			`MPT_SRC_FALL: count_event = ~level & prev_level;
			default: count_event = level ^ prev_level;
		endcase
	end
endmodule // mpt_edge_detect

/* File: verilog/mpt_pwm_timer.v */
`timescale 1ns/1ps
// Overview of operation
// - Period match sets common cycle end.
// - Double-edge output n uses matches n-1 and n.
// - Two matches place set and clear edges.
// - Counts clock or capture input events.
// - Seven matches, single or double edges mixed.
// - Each match continues, stops or resets; interrupt.
// - Single-edge outputs rise at cycle start.
// - Any period and width, same rate.
// - Released shadow values load at cycle end.
// - Outputs idle low when pulse mode off.
// - 32-bit counter behind 32-bit prescaler.
module mpt_pwm_timer (
	input wire core_clk,
	input wire reset_n,
	input wire counter_enable,
	input wire counter_clear,
	input wire pwm_enable,
	input wire [1:0] src_mode,
	input wire [1:0] cap_sel,
	input wire [1:0] cap_in,
	input wire [31:0] prescale_limit,
	input wire [31:0] match_wdata,
	input wire [2:0] match_widx,
	input wire match_write,
	input wire [6:0] match_release,
	input wire [6:0] match_irq_en,
	input wire [13:0] match_action,
	input wire [5:0] double_edge_sel,
	input wire [6:0] match_irq_clear,
	output reg [31:0] count_value,
	output reg [31:0] prescale_value,
	output wire [5:0] pulse_out,
	output wire [6:0] match_irq,
	output reg counter_stopped
);
`include "mpt_map.vh"
	// =====================================
	// Storage
	wire [31:0] active [0:6];
	wire count_event;
	wire tick;
	wire [6:0] hit;
	wire cycle_end;
	reg next_stop;
	reg next_reset;
	integer k;

	// =====================================
	// Count event source
	mpt_edge_detect u_edge (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.cap_sel(cap_sel),
		.cap_in(cap_in),
		.src_mode(src_mode),
		.count_event(count_event)
	);

	// =====================================
	// Prescaler and counter
	assign tick = counter_enable & ~counter_stopped & count_event &
		(prescale_value == prescale_limit);
	assign cycle_end = tick & hit[0];

	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1) begin : g_hit
			assign hit[g] = (count_value == active[g]);
		end
	endgenerate

	always @* begin
		next_stop = 1'b0;
		next_reset = 1'b0;
		for (k = 0; k < 7; k = k + 1) begin
			if (tick && hit[k]) begin
				if (match_action[2*k +: 2] == `MPT_ACT_STOP) begin
					next_stop = 1'b1;
				end
				if (match_action[2*k +: 2] == `MPT_ACT_RESET) begin
					next_reset = 1'b1;
				end
			end
		end
		if (pwm_enable && cycle_end) begin
			next_reset = 1'b1;
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prescale_value <= `MPT_ZERO32;
			count_value <= `MPT_ZERO32;
			counter_stopped <= 1'b0;
		end else if (counter_clear) begin
			prescale_value <= `MPT_ZERO32;
			count_value <= `MPT_ZERO32;
			counter_stopped <= 1'b0;
		end else begin
			if (counter_enable && !counter_stopped && count_event) begin
				if (prescale_value == prescale_limit) begin
					prescale_value <= `MPT_ZERO32;
				end else begin
					prescale_value <= prescale_value + `MPT_ONE32;
				end
			end
			if (next_reset) begin
				count_value <= `MPT_ZERO32;
			end else if (tick) begin
				count_value <= count_value + `MPT_ONE32;
			end
			if (next_stop) begin
				counter_stopped <= 1'b1;
			end else if (!counter_enable) begin
				counter_stopped <= 1'b0;
			end
		end
	end

	// =====================================
	// Shadow, release and match flags
	generate
		for (g = 0; g < 7; g = g + 1) begin : g_match
			reg [31:0] shadow_q;
			reg [31:0] active_q;
			reg pend_q;
			reg irq_q;
			reg [31:0] next_shadow;
			reg [31:0] next_active;
			reg next_pend;
			reg next_irq;
			wire write_hit;
			assign write_hit = match_write && (match_widx == g);
			assign active[g] = active_q;
			assign match_irq[g] = irq_q;
			// =====================================
			// Per-match next values
			always @* begin
				next_shadow = shadow_q;
				if (write_hit) begin
					next_shadow = match_wdata;
				end
			end
			always @* begin
				next_active = active_q;
				if (!pwm_enable || (cycle_end && pend_q)) begin
					next_active = next_shadow;
				end
			end
			always @* begin
				next_pend = pend_q;
				if (match_release[g]) begin
					next_pend = 1'b1;
				end else if (cycle_end || !pwm_enable) begin
					next_pend = 1'b0;
				end
			end
			always @* begin
				next_irq = irq_q;
				if (tick && hit[g] && match_irq_en[g]) begin
					next_irq = 1'b1;
				end else if (match_irq_clear[g]) begin
					next_irq = 1'b0;
				end
			end
			always @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					shadow_q <= `MPT_ZERO32;
					active_q <= `MPT_ZERO32;
					pend_q <= 1'b0;
					irq_q <= 1'b0;
				end else begin
					shadow_q <= next_shadow;
					active_q <= next_active;
					pend_q <= next_pend;
					irq_q <= next_irq;
				end
			end
		end
	endgenerate

	// =====================================
	// Pulse outputs; channel n uses match n (single) or n-1 and n (double, channels 2 to 6 only)
	generate
		for (g = 1; g < 7; g = g + 1) begin : g_out
			reg pulse_q;
			reg next_pulse;
			assign pulse_out[g-1] = pulse_q;
			always @* begin
				next_pulse = pulse_q;
				if (!pwm_enable) begin
					next_pulse = 1'b0;
				end else if (double_edge_sel[g-1] && g > 1) begin
					if (tick && hit[g-1]) begin
						next_pulse = 1'b1;
					end else if (tick && hit[g]) begin
						next_pulse = 1'b0;
					end
				end else if (cycle_end || counter_clear) begin
					next_pulse = (active[g] != `MPT_ZERO32);
				end else if (tick && hit[g]) begin
					next_pulse = 1'b0;
				end
			end
			always @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					pulse_q <= 1'b0;
				end else begin
					pulse_q <= next_pulse;
				end
			end
		end
	endgenerate
endmodule // mpt_pwm_timer

/* File: test/mpt_sva.sv */
`timescale 1ns/1ps
module mpt_sva (
	input wire core_clk,
	input wire reset_n,
	input wire counter_enable,
	input wire counter_clear,
	input wire pwm_enable,
	input wire [1:0] src_mode,
	input wire [31:0] prescale_limit,
	input wire [13:0] match_action,
	input wire [6:0] match_irq_en,
	input wire [6:0] match_irq_clear,
	input wire [31:0] count_value,
	input wire [31:0] prescale_value,
	input wire [5:0] pulse_out,
	input wire [6:0] match_irq,
	input wire counter_stopped
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_run;
		counter_enable && !counter_clear && !counter_stopped && !pwm_enable
			&& src_mode == 2'h0 && match_action == 14'h0;
	endsequence
	a_clear_zero: assert property (counter_clear |=> !count_value && !prescale_value)
		else $error("clear missed");
	a_pre_step: assert property (s_run ##0 prescale_value < prescale_limit
		|=> prescale_value == $past(prescale_value) + 1) else $error("prescale step");
	a_tick_inc: assert property (s_run ##0 prescale_value == prescale_limit
		|=> !prescale_value && count_value == $past(count_value) + 1) else $error("tick");
	a_idle_hold: assert property (!counter_enable && !counter_clear
		|=> $stable(count_value)) else $error("idle moved");
	a_pwm_low: assert property (!pwm_enable |=> !pulse_out)
		else $error("pulse in timer mode");
	a_stop_hold: assert property (counter_stopped && counter_enable && !counter_clear
		|=> counter_stopped && $stable(count_value)) else $error("stop lost");
	a_irq_keep: assert property (match_irq[0] && !match_irq_clear[0] |=> match_irq[0])
		else $error("flag dropped");
	a_irq_gate: assert property (!match_irq_en[0] && !match_irq[0] |=> !match_irq[0])
		else $error("flag unenabled");
endmodule // mpt_sva
bind mpt_pwm_timer mpt_sva mpt_sva_i (.*);

/* File: test/mpt_load.sv */
`timescale 1ns/1ps
module mpt_load (
	input wire core_clk,
	input wire drive,
	output reg [7:0] rises
);
	reg last = 0;
	initial rises = 0;
	always @(posedge core_clk) begin
		last <= drive;
		if (drive && !last) rises <= rises + 8'h01;
	end
endmodule // mpt_load

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	reg core_clk = 0, reset_n = 0, counter_enable = 0, counter_clear = 0, pwm_enable = 0;
	reg match_write = 0;
	reg [1:0] src_mode = 0, cap_sel = 0, cap_in = 0;
	reg [31:0] prescale_limit = 0, match_wdata = 0;
	reg [2:0] match_widx = 0;
	reg [6:0] match_release = 0, match_irq_en = 0, match_irq_clear = 0;
	reg [13:0] match_action = 0;
	reg [5:0] double_edge_sel = 0;
	wire [31:0] count_value, prescale_value;
	wire [5:0] pulse_out;
	wire [6:0] match_irq;
	wire counter_stopped;
	wire [7:0] rises;
	integer n_errors = 0, comparisons = 0, k;
	reg [7:0] r;
	mpt_pwm_timer mpt_pwm_timer_i (.*);
	mpt_load mpt_load_i (.core_clk(core_clk), .drive(pulse_out[0]), .rises(rises));
	always #12.5 core_clk = ~core_clk;
	task step;
		#2 @(posedge core_clk) #2;
	endtask
	task chk(input [31:0] seen, input [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task wc(input [31:0] v);
		for (k = 0; k < 300 && count_value !== v; k++) step;
		chk(count_value, v, "count");
	endtask
	task wm(input [2:0] i, input [31:0] d);
		match_widx = i;
		match_wdata = d;
		match_write = 1;
		step;
		match_write = 0;
		step;
	endtask
	task pat(input [5:0] a, b, c);
		wc(0);
		wc(2);
		chk(pulse_out & 6'h2b, a, "pulse");
		wc(5);
		chk(pulse_out & 6'h2b, b, "pulse");
		wc(8);
		chk(pulse_out & 6'h2b, c, "pulse");
	endtask
	task print_verdict;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#300000 n_errors++;
		print_verdict;
	end
	initial begin
		repeat (5) step;
		reset_n = 1;
		{counter_enable, pwm_enable, double_edge_sel} = 8'hca;
		wm(0, 9); wm(1, 3); wm(2, 6); wm(3, 7); wm(4, 2); wm(6, 0);
		match_release = 7'h7f;
		step;
		match_release = 0;
		wc(9);
		wc(0);
		r = rises;
		pat(6'h09, 6'h02, 6'h08);
		chk(rises - r, 1, "rises");
		$display("pwm test done");
		wm(1, 5);
		pat(6'h09, 6'h02, 6'h08);
		wc(3);
		match_release = 7'h02;
		step;
		match_release = 0;
		wc(0);
		pat(6'h09, 6'h01, 6'h08);
		$display("release test done");
		{pwm_enable, counter_clear, match_action, match_irq_en} = 23'h200081;
		step;
		counter_clear = 0;
		wc(9);
		repeat (3) step;
		chk({counter_stopped, match_irq[0], pulse_out}, 8'hc0, "stop");
		match_irq_clear = 1;
		step;
		match_irq_clear = 0;
		step;
		chk(match_irq, 0, "irq");
		{counter_enable, match_action} = 0;
		step;
		counter_enable = 1;
		wc(12);
		{counter_clear, src_mode} = 3'h5;
		step;
		counter_clear = 0;
		repeat (4) begin
			cap_in = 1;
			step;
			step;
			cap_in = 0;
			step;
			step;
		end
		chk(count_value, 4, "capture");
		{src_mode, prescale_limit} = 2;
		repeat (9) step;
		chk(count_value, 7, "prescaled count");
		chk(prescale_value, 0, "prescale wrap");
		$display("timer test done");
		print_verdict;
	end
endmodule // tb_top
